// ===== rtl/exec_defs.svh
/*
 * Offsets, reset values and timing constants of the execution slice.
 * Assumes inclusion by bare name after the package; holds no logic.
 */
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH

// ----------------------------------------
// Register offsets, byte addresses
// ----------------------------------------
`define ADDR_W        8
`define OFF_CMD       8'h00
`define OFF_DEST      8'h04
`define OFF_SRC       8'h08
`define OFF_QUEUE     8'h0c
`define OFF_FLAGS     8'h10
`define OFF_DIR_LOW   8'h14
`define OFF_DIR_HIGH  8'h18
`define OFF_STATUS    8'h1c

// ----------------------------------------
// Widths and field positions
// ----------------------------------------
`define WORD_W        32
`define CMD_W         13
`define BIT_CARRY     0
`define BIT_ZERO      1
`define PIN_IMM_W     9
`define PIN_EXT_W     11
`define QCNT_W        5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_WORD      32'h0000_0000
`define RST_CMD       13'h1fff
`define ONE_WORD      32'h0000_0001
`define HTRANS_NONSEQ 2'h2
`define HRESP_OKAY    1'h0

// ----------------------------------------
// Condition codes and timing
// ----------------------------------------
`define CONDITION_FIELD_BE       4'he
`define CONDITION_FIELD_GT       4'h1
`define CONDITION_FIELD_ALWAYS   4'hf
`define EXEC_CYCLES   2

`endif

// ===== rtl/exec_pkg.sv
/*
 * Types of the execution slice: operation codes, command layout, states.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package exec_pkg;

	// ----------------------------------------
	// Operations, codes 0 to 5 in list order
	// ----------------------------------------
	typedef enum logic [2:0] {
		modulus_decrement,
		one_hot_decode,
		dir_from_carry,
		dir_from_not_carry,
		dir_force_output,
		dir_force_input
	} op_e;

	// ----------------------------------------
	// Command word, low 13 bits of CMD
	// ----------------------------------------
	typedef struct packed {
		logic       use_src;
		logic       dest_immediate_extend;
		logic       dest_imm;
		logic       update_both_flags_effect;
		logic       update_zero_effect;
		logic       update_carry_effect;
		logic [2:0] op;
		logic [3:0] condition_field;
	} cmd_s;

	typedef struct packed {
		logic zero;
		logic carry;
	} flags_s;

	typedef enum logic [1:0] {
		st_idle,
		st_wait,
		st_exec
	} state_e;

endpackage

// ===== rtl/condition_field_modulus_decrement_decode_pindir_exec.sv
/*
 * Execution slice: condition gating, modulus decrement, one-hot decode and
 * pin-direction operations, reached as an AHB-Lite slave.
 * Assumes a single AHB-Lite master, whole-word single transfers, and that
 * hready is this slave's own hreadyout.
 */
`timescale 1ns/1ps
`include "exec_defs.svh"

module condition_field_modulus_decrement_decode_pindir_exec
	import exec_pkg::*;
(
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [`WORD_W-1:0]   hwdata,
	input  wire logic                 hready,
	output logic      [`WORD_W-1:0]   hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	output logic      [`WORD_W-1:0]   dir_reg_low_port,
	output logic      [`WORD_W-1:0]   dir_reg_high_port,
	output logic                      carry_flag,
	output logic                      zero_flag,
	output logic                      busy
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// Every code reads as a truth table indexed by {carry, zero}
	function automatic logic condition_field_passes(input logic [3:0] code, input logic c, input logic z);
		condition_field_passes = code[{c, z}];
	endfunction

	// Mask from base up to base plus count, modulo 32
	function automatic logic [`WORD_W-1:0] range_mask(input logic [4:0] base, input logic [4:0] cnt);
		logic [4:0] off;
		range_mask = `RST_WORD;
		for (int i = 0; i < `WORD_W; i++) begin
			off = 5'(i) - base;
			range_mask[i] = (off <= cnt);
		end
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	state_e             state;
	cmd_s               cmd;
	logic [`ADDR_W-1:0] wr_addr;
	logic               wr_pend;
	logic [`WORD_W-1:0] dest_val;
	logic [`WORD_W-1:0] src_val;
	logic [`WORD_W-1:0] queue_val;
	logic               queue_armed;
	logic               last_ran;
	state_e             next_state;
	logic [`WORD_W-1:0] next_dest;
	logic [`WORD_W-1:0] next_low;
	logic [`WORD_W-1:0] next_high;
	logic               next_carry;
	logic               next_zero;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire logic               addr_phase = hsel && htrans == `HTRANS_NONSEQ && hready;
	wire logic [`ADDR_W-1:0] a_off      = haddr[`ADDR_W-1:0];
	wire logic               cmd_take   = addr_phase && hwrite && a_off == `OFF_CMD;
	wire logic               wr_dest    = wr_pend && wr_addr == `OFF_DEST;
	wire logic               wr_src     = wr_pend && wr_addr == `OFF_SRC;
	wire logic               wr_queue   = wr_pend && wr_addr == `OFF_QUEUE;
	wire logic               wr_flags   = wr_pend && wr_addr == `OFF_FLAGS;
	wire logic               wr_low     = wr_pend && wr_addr == `OFF_DIR_LOW;
	wire logic               wr_high    = wr_pend && wr_addr == `OFF_DIR_HIGH;
	wire logic               wr_cmd     = wr_pend && wr_addr == `OFF_CMD;

	wire logic [`WORD_W-1:0] flags_word  = {30'h0, zero_flag, carry_flag};
	wire logic [`WORD_W-1:0] status_word = {29'h0, last_ran, queue_armed, busy};
	wire logic [`WORD_W-1:0] rd_word =
		a_off == `OFF_CMD      ? {19'h0, cmd}       :
		a_off == `OFF_DEST     ? dest_val           :
		a_off == `OFF_SRC      ? src_val            :
		a_off == `OFF_QUEUE    ? queue_val          :
		a_off == `OFF_FLAGS    ? flags_word         :
		a_off == `OFF_DIR_LOW  ? dir_reg_low_port   :
		a_off == `OFF_DIR_HIGH ? dir_reg_high_port  :
		a_off == `OFF_STATUS   ? status_word        :
		`RST_WORD;

	// ----------------------------------------
	// Condition and decrement
	// ----------------------------------------
	wire logic run_now  = state == st_exec;
	wire logic condition_field_ok  = condition_field_passes(cmd.condition_field, carry_flag, zero_flag);
	wire logic commit   = run_now && condition_field_ok;
	wire op_e  op       = op_e'(cmd.op);
	wire logic upd_c    = cmd.update_carry_effect || cmd.update_both_flags_effect;
	wire logic upd_z    = cmd.update_zero_effect || cmd.update_both_flags_effect;

	// No clamp against the source: any nonzero value simply counts down
	wire logic               dec_reload = dest_val == `RST_WORD;
	wire logic [`WORD_W-1:0] dec_result = dec_reload ? src_val : dest_val - `ONE_WORD;
	wire logic [4:0]         hot_index  = cmd.use_src ? src_val[4:0] : dest_val[4:0];
	wire logic [`WORD_W-1:0] hot_word   = `ONE_WORD << hot_index;

	// ----------------------------------------
	// Pin selector
	// ----------------------------------------
	// Queue prefix only counts for a register operand
	wire logic [`PIN_EXT_W-1:0] imm_pins = {2'h0, dest_val[`PIN_IMM_W-1:0]};
	wire logic [`PIN_EXT_W-1:0] reg_pins =
		queue_armed ? {queue_val[`QCNT_W-1:0], dest_val[5:0]} : dest_val[`PIN_EXT_W-1:0];
	wire logic [`PIN_EXT_W-1:0] pin_word =
		cmd.dest_immediate_extend ? dest_val[`PIN_EXT_W-1:0] :
		cmd.dest_imm ? imm_pins : reg_pins;
	wire logic [5:0]         base_pin = pin_word[5:0];
	wire logic [4:0]         pin_cnt  = pin_word[10:6];
	wire logic               hi_port  = base_pin[5];
	wire logic [`WORD_W-1:0] dir_cur  = hi_port ? dir_reg_high_port : dir_reg_low_port;
	wire logic [`WORD_W-1:0] pin_mask = range_mask(base_pin[4:0], pin_cnt);
	wire logic               orig_bit = dir_cur[base_pin[4:0]];
	wire logic               fill =
		op == dir_from_carry     ? carry_flag  :
		op == dir_from_not_carry ? !carry_flag :
		op == dir_force_output;
	wire logic [`WORD_W-1:0] dir_new = (dir_cur & ~pin_mask) | (fill ? pin_mask : `RST_WORD);
	wire logic               is_dir  = op inside {dir_from_carry, dir_from_not_carry,
		dir_force_output, dir_force_input};

	// ----------------------------------------
	// Next values
	// ----------------------------------------
	always_comb begin
		next_dest  = wr_dest ? hwdata : dest_val;
		next_low   = wr_low ? hwdata : dir_reg_low_port;
		next_high  = wr_high ? hwdata : dir_reg_high_port;
		next_carry = wr_flags ? hwdata[`BIT_CARRY] : carry_flag;
		next_zero  = wr_flags ? hwdata[`BIT_ZERO] : zero_flag;
		if (commit) begin
			if (op == modulus_decrement) begin
				next_dest = dec_result;
				if (upd_c)
					next_carry = dec_reload;
				if (upd_z)
					next_zero = dec_result == `RST_WORD;
			end else if (op == one_hot_decode) begin
				next_dest = hot_word;
			end else if (is_dir) begin
				if (hi_port)
					next_high = dir_new;
				else
					next_low = dir_new;
				if (cmd.update_both_flags_effect) begin
					next_carry = orig_bit;
					next_zero  = orig_bit;
				end
			end
		end
	end

	// Two cycles per instruction, taken or not
	always_comb begin
		next_state = state;
		unique case (state)
			st_idle: if (wr_cmd) next_state = st_wait;
			st_wait: next_state = st_exec;
			st_exec: next_state = st_idle;
		endcase
	end

	// ----------------------------------------
	// Bus side flops
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= '0;
			hrdata  <= `RST_WORD;
			hresp   <= `HRESP_OKAY;
		end else begin
			wr_pend <= addr_phase && hwrite;
			if (addr_phase)
				wr_addr <= a_off;
			if (addr_phase && !hwrite)
				hrdata <= rd_word;
		end
	end

	// Command write holds its data phase until the instruction retires
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hreadyout <= 1'b1;
		else if (cmd_take)
			hreadyout <= 1'b0;
		else if (run_now)
			hreadyout <= 1'b1;
	end

	// ----------------------------------------
	// Execution flops
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= st_idle;
			cmd   <= cmd_s'(`RST_CMD);
			busy  <= 1'b0;
		end else begin
			state <= next_state;
			busy  <= next_state != st_idle;
			if (wr_cmd && state == st_idle)
				cmd <= cmd_s'(hwdata[`CMD_W-1:0]);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dest_val          <= `RST_WORD;
			src_val           <= `RST_WORD;
			dir_reg_low_port  <= `RST_WORD;
			dir_reg_high_port <= `RST_WORD;
			carry_flag        <= 1'b0;
			zero_flag         <= 1'b0;
		end else begin
			dest_val          <= next_dest;
			dir_reg_low_port  <= next_low;
			dir_reg_high_port <= next_high;
			carry_flag        <= next_carry;
			zero_flag         <= next_zero;
			if (wr_src)
				src_val <= hwdata;
		end
	end

	// Prefix lasts for the next instruction only, run or skipped
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			queue_val   <= `RST_WORD;
			queue_armed <= 1'b0;
			last_ran    <= 1'b0;
		end else begin
			if (wr_queue) begin
				queue_val   <= hwdata;
				queue_armed <= 1'b1;
			end else if (run_now) begin
				queue_armed <= 1'b0;
			end
			if (run_now)
				last_ran <= condition_field_ok;
		end
	end

endmodule // condition_field_modulus_decrement_decode_pindir_exec

// ===== bench/exec_assertions.sv
/*
 * Port checks of the execution slice.
 * Assumes it is bound to the slice top, whose hready is its own hreadyout.
 */
`timescale 1ns/1ps
module exec_checker (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic [31:0] dir_reg_low_port,
	input wire logic [31:0] dir_reg_high_port,
	input wire logic        carry_flag,
	input wire logic        zero_flag,
	input wire logic        busy
);
	// ----------------------------------------
	// Write phase tracking
	// ----------------------------------------
	logic       wphase;
	logic [7:0] waddr;
	wire        take = hsel && htrans == 2'h2 && hready;
	wire        cmd_dp = wphase && waddr == 8'h00;
	wire [1:0]  flg = {zero_flag, carry_flag};
	wire [63:0] dirs = {dir_reg_high_port, dir_reg_low_port};
	wire [2:0]  op = hwdata[6:4];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wphase <= 1'b0;
			waddr  <= 8'h00;
		end else begin
			wphase <= take && hwrite;
			waddr  <= haddr[7:0];
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_cmd_wait: assert property (take && hwrite && haddr[7:0] == 8'h00 |=> !hreadyout[*3] ##1 hreadyout)
		else $error("command wait wrong");
	a_busy_pulse: assert property ($rose(busy) |=> busy ##1 !busy)
		else $error("busy length wrong");
	a_dir_quiet: assert property (!$stable(dirs) |-> $fell(busy) || $past(wphase) && $past(waddr) inside {8'h14, 8'h18})
		else $error("direction changed idle");
	a_flag_quiet: assert property (!$stable(flg) |-> $fell(busy) || $past(wphase) && $past(waddr) == 8'h10)
		else $error("flags changed idle");
	a_be_false: assert property (cmd_dp && hwdata[3:0] == 4'he && flg == 2'b00 |=> $stable({dirs, flg})[*3])
		else $error("false condition acted");
	a_gt_false: assert property (cmd_dp && hwdata[3:0] == 4'h1 && flg != 2'b00 |=> $stable({dirs, flg})[*3])
		else $error("false condition acted");
	a_force_flags: assert property (cmd_dp && op == 3'h4 && !hwdata[9] |=> $stable(flg)[*3])
		else $error("force op touched flags");
	a_decode_dirs: assert property (cmd_dp && op == 3'h1 |=> $stable(dirs)[*3])
		else $error("decode touched direction");
	a_both_flags: assert property (cmd_dp && hwdata[3:0] == 4'hf && hwdata[9] && op inside {[3'h2:3'h5]}
		|-> ##3 carry_flag == zero_flag)
		else $error("flags differ after base load");
endmodule // exec_checker

bind condition_field_modulus_decrement_decode_pindir_exec exec_checker i_exec_checker (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.dir_reg_low_port(dir_reg_low_port), .dir_reg_high_port(dir_reg_high_port), .carry_flag(carry_flag),
	.zero_flag(zero_flag), .busy(busy));

// ===== bench/tb_condition_field_modulus_decrement_decode_pindir_exec.sv
/*
 * Self-checking bench of the execution slice over AHB-Lite.
 * Assumes a single master and hready looped from hreadyout.
 */
`timescale 1ns/1ps
`include "exec_defs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_condition_field_modulus_decrement_decode_pindir_exec
	import exec_pkg::*;
;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic        rd_dp = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] e_now, d0, dv, q;
	wire  [31:0] hrdata, dlo, dhi;
	wire         hready, hresp, carry_flag, zero_flag, busy;
	int          miscompares = 0;
	int          tests_run = 0;
	logic [31:0] exp_q[$];

	condition_field_modulus_decrement_decode_pindir_exec i_condition_field_modulus_decrement_decode_pindir_exec (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .dir_reg_low_port(dlo),
		.dir_reg_high_port(dhi), .carry_flag(carry_flag), .zero_flag(zero_flag), .busy(busy));

	initial begin
		forever #5 hclk = ~hclk;
	end

	// ----------------------------------------
	// Bus master and result watcher
	// ----------------------------------------
	task automatic tally_and_finish();
		if (miscompares == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		hsel <= 1'b1;
		htrans <= `HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {24'h0, a};
		do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 64);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 64);
		if (n >= 64) begin
			miscompares++;
			tally_and_finish();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		xfer(1'b0, a, 32'h0);
	endtask

	task automatic run(input logic [3:0] c, input op_e o, input logic [5:0] f);
		wr(`OFF_CMD, {19'h0, f, o, c});
	endtask

	// Range wraps inside one 32-bit group
	function automatic logic [31:0] fill(logic [31:0] r, logic [4:0] b, logic [4:0] n, logic v);
		for (int i = 0; i <= n; i++) r[(b + i) % 32] = v;
		return r;
	endfunction

	always @(posedge hclk) begin
		if (rd_dp && hready) begin
			e_now = exp_q.pop_front();
			`CHK(hrdata, e_now)
		end
		rd_dp <= hsel && htrans == `HTRANS_NONSEQ && !hwrite && hready;
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		logic [4:0] cnt;
		logic [5:0] base;
		logic [1:0] fl;
		logic [3:0] cc;
		logic       go, orig, v;
		void'($urandom(41));
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		rd(`OFF_CMD, 32'h1fff);
		wr(8'h20, $urandom());
		rd(8'h20, 32'h0);
		d0 = $urandom_range(200, 2);
		wr(`OFF_SRC, d0);
		wr(`OFF_DEST, 32'h0);
		run(4'hf, modulus_decrement, 6'h03);
		rd(`OFF_DEST, d0);
		rd(`OFF_FLAGS, 32'h1);
		wr(`OFF_DEST, 32'h1);
		run(4'hf, modulus_decrement, 6'h03);
		rd(`OFF_DEST, 32'h0);
		rd(`OFF_FLAGS, 32'h2);
		wr(`OFF_DEST, d0 + 32'h3);
		run(4'hf, modulus_decrement, 6'h03);
		rd(`OFF_DEST, d0 + 32'h2);
		rd(`OFF_FLAGS, 32'h0);
		for (int k = 0; k < 12; k++) begin
			cc = (k < 4) ? 4'he : (k < 8) ? 4'h1 : 4'hf;
			fl = k[1:0];
			go = (cc == 4'he) ? |fl : (cc == 4'h1) ? ~|fl : 1'b1;
			wr(`OFF_FLAGS, {30'h0, fl});
			wr(`OFF_DEST, 32'h5);
			run(cc, modulus_decrement, 6'h0);
			rd(`OFF_DEST, go ? 32'h4 : 32'h5);
			rd(`OFF_FLAGS, {30'h0, fl});
			rd(`OFF_STATUS, {29'h0, go, 2'b00});
		end
		d0 = $urandom();
		wr(`OFF_SRC, d0);
		run(4'hf, one_hot_decode, 6'h20);
		rd(`OFF_DEST, 32'h1 << d0[4:0]);
		d0 = $urandom();
		wr(`OFF_DEST, d0);
		run(4'hf, one_hot_decode, 6'h00);
		rd(`OFF_DEST, 32'h1 << d0[4:0]);
		for (int i = 0; i < 16; i++) begin
			d0 = $urandom();
			dv = $urandom();
			q = $urandom();
			fl = dv[13:12];
			base = dv[5:0];
			cnt = (i % 4 == 1) ? {2'b00, dv[8:6]} : (i % 4 == 3) ? q[4:0] : dv[10:6];
			orig = base[5] ? ~d0[base[4:0]] : d0[base[4:0]];
			v = (i < 4) ? fl[0] : (i < 8) ? ~fl[0] : (i < 12);
			wr(`OFF_DIR_LOW, d0);
			wr(`OFF_DIR_HIGH, ~d0);
			wr(`OFF_FLAGS, {30'h0, fl});
			wr(`OFF_DEST, dv);
			if (i % 4 == 3) wr(`OFF_QUEUE, q);
			run(4'hf, op_e'(3'(2 + i / 4)), {1'b0, i % 4 == 2, i % 4 == 1, i[0], 2'b00});
			rd(`OFF_DIR_LOW, base[5] ? d0 : fill(d0, base[4:0], cnt, v));
			rd(`OFF_DIR_HIGH, base[5] ? fill(~d0, base[4:0], cnt, v) : ~d0);
			rd(`OFF_FLAGS, i[0] ? {30'h0, orig, orig} : {30'h0, fl});
		end
		@(posedge hclk);
		tally_and_finish();
	end
endmodule // tb_condition_field_modulus_decrement_decode_pindir_exec
